// ### design/mpsr_top.sv
/*
  Multipurpose status/count register with an AXI4-Lite slave.
  Assumes drive status and header words arrive as synchronous inputs with
  one-cycle strobes, and that the transfer engine pulses word_done per word.
*/
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module mpsr_top
  import mpsr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic status_done,
  input wire logic write_protected_flag,
  input wire logic seek_timeout_flag,
  input wire logic protected_write_error,
  input wire logic drive_type_flag,
  input wire logic head_select,
  input wire logic drive_ready,
  input wire logic drive_seeking,
  input wire logic header_valid,
  input wire logic [15:0] header_word,
  input wire logic word_done,
  output logic status_request,
  output logic status_reset_opt,
  output logic xfer_end
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] build_status(
    input logic wp, input logic sto, input logic pwe, input logic vc,
    input logic dt, input logic hs, input logic rdy, input logic sk);
    logic [15:0] s;
    s = 16'h0000;
    s[MPSR_ST_WPROT] = wp;
    s[MPSR_ST_SEEKTO] = sto;
    s[MPSR_ST_PWERR] = pwe;
    s[MPSR_ST_VOLCHG] = vc;
    s[MPSR_ST_DTYPE] = dt;
    s[MPSR_ST_HEAD] = hs;
    s[MPSR_ST_COVER] = ~rdy;
    s[MPSR_ST_BRUSH] = ~rdy;
    s[MPSR_ST_HEADSOUT] = rdy;
    if (!rdy)
      s[2:0] = MPSR_STATE_LOAD;
    else if (sk)
      s[2:0] = MPSR_STATE_SEEK;
    else
      s[2:0] = MPSR_STATE_LOCK;
    return s;
  endfunction

  function automatic logic word_hit(input logic [3:0] a, input logic [7:0] off);
    return a[3:2] == off[3:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] bresp_reg, bresp_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [3:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic aw_have_reg, aw_have_next;
  logic w_have_reg, w_have_next;

  mpsr_view_e view_reg, view_next;
  logic [15:0] status_reg, status_next;
  // Header words are not reset: a read before the first word arrives
  // shows whatever the previous header left behind.
  logic [15:0] hdr_mem [0:2];
  logic [15:0] hdr_wdata;
  logic [1:0] hdr_wptr_reg, hdr_wptr_next;
  logic [1:0] hdr_rptr_reg, hdr_rptr_next;
  logic hdr_we;
  logic [12:0] wcount_reg, wcount_next;
  logic [2:0] wc_top_reg, wc_top_next;
  logic volchg_reg, volchg_next;
  logic ready_prev_reg, ready_prev_next;
  logic req_reg, req_next;
  logic rstopt_reg, rstopt_next;
  logic end_reg, end_next;
  logic busy_reg, busy_next;
  logic [15:0] mpr_view;
  logic wr_fire, rd_fire, mpr_read;
  logic [12:0] wc_inc;
  logic cmd_write, status_cmd, header_cmd, xfer_cmd;

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign status_request = req_reg;
  assign status_reset_opt = rstopt_reg;
  assign xfer_end = end_reg;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data taken in either order, one write
  // and one read outstanding.
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
  assign rd_fire = s_axi_arvalid && arready_reg;
  assign mpr_read = rd_fire && word_hit(s_axi_araddr, MPSR_OFF_MPR);

  always_comb
  begin
    awready_next = awready_reg;
    wready_next = wready_reg;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_awvalid && awready_reg)
    begin
      aw_have_next = 1'b1;
      awready_next = 1'b0;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg)
    begin
      w_have_next = 1'b1;
      wready_next = 1'b0;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      bvalid_next = 1'b1;
      bresp_next = (word_hit(awaddr_reg, MPSR_OFF_MPR) || word_hit(awaddr_reg, MPSR_OFF_CMD))
        ? 2'h0 : 2'h2;
    end
    if (bvalid_reg && s_axi_bready)
    begin
      bvalid_next = 1'b0;
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      awready_next = 1'b1;
      wready_next = 1'b1;
    end
    if (rd_fire)
    begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      rresp_next = 2'h0;
      if (word_hit(s_axi_araddr, MPSR_OFF_MPR))
        rdata_next = {16'h0000, mpr_view};
      else if (word_hit(s_axi_araddr, MPSR_OFF_STAT))
        rdata_next = {28'h0000000, end_reg, busy_reg, req_reg, volchg_reg};
      else
      begin
        rdata_next = 32'h00000000;
        rresp_next = 2'h2;
      end
    end
    if (rvalid_reg && s_axi_rready)
    begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= 2'h0;
    end
    else
    begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Multipurpose register contents and view selection
  always_comb
  begin
    case (view_reg)
      MPSR_V_STATUS: mpr_view = status_reg;
      MPSR_V_HEADER: mpr_view = hdr_mem[hdr_rptr_reg];
      MPSR_V_XFER: mpr_view = {wc_top_reg, wcount_reg};
      MPSR_V_IDLE: mpr_view = MPSR_MPR_RST;
      default: mpr_view = MPSR_MPR_RST;
    endcase
  end

  assign wc_inc = wcount_reg + 13'h0001;
  // Command decode is shared so that a fresh command landing in the cycle
  // of a completion wins over that completion's clear.
  assign cmd_write = wr_fire && word_hit(awaddr_reg, MPSR_OFF_CMD) && wstrb_reg[0];
  assign status_cmd = cmd_write && wdata_reg[1:0] == MPSR_CMD_STATUS;
  assign header_cmd = cmd_write && wdata_reg[1:0] == MPSR_CMD_HEADER;
  assign xfer_cmd = cmd_write && wdata_reg[1:0] == MPSR_CMD_XFER;
  assign hdr_we = header_valid && view_reg == MPSR_V_HEADER && hdr_wptr_reg != 2'h3;
  // Word two is forced to zero whatever the drive returns
  assign hdr_wdata = (hdr_wptr_reg == 2'h1) ? 16'h0000 : header_word;

  always_comb
  begin
    view_next = view_reg;
    status_next = status_reg;
    hdr_wptr_next = hdr_wptr_reg;
    hdr_rptr_next = hdr_rptr_reg;
    wcount_next = wcount_reg;
    wc_top_next = wc_top_reg;
    volchg_next = volchg_reg;
    ready_prev_next = drive_ready;
    req_next = req_reg;
    rstopt_next = rstopt_reg;
    end_next = 1'b0;
    busy_next = busy_reg;
    if (drive_ready && !ready_prev_reg)
      volchg_next = 1'b1;
    if (wr_fire && word_hit(awaddr_reg, MPSR_OFF_MPR) && wstrb_reg[0] && wstrb_reg[1])
    begin
      wcount_next = wdata_reg[12:0];
      wc_top_next = wdata_reg[15:13];
      view_next = MPSR_V_XFER;
    end
    if (cmd_write)
    begin
      case (wdata_reg[1:0])
        MPSR_CMD_STATUS:
        begin
          req_next = 1'b1;
          rstopt_next = wdata_reg[MPSR_CMD_RST_BIT];
          view_next = MPSR_V_STATUS;
        end
        MPSR_CMD_HEADER:
        begin
          hdr_wptr_next = 2'h0;
          hdr_rptr_next = 2'h0;
          view_next = MPSR_V_HEADER;
        end
        MPSR_CMD_XFER:
        begin
          busy_next = 1'b1;
          view_next = MPSR_V_XFER;
        end
        default:
          view_next = view_reg;
      endcase
    end
    if (status_done && req_reg)
    begin
      if (!status_cmd)
        req_next = 1'b0;
      // The reset option clears the error bits ahead of the sample, but a
      // fresh ready edge in that very cycle still sets volume changed.
      if (rstopt_reg && !(drive_ready && !ready_prev_reg))
        volchg_next = 1'b0;
      status_next = build_status(write_protected_flag,
        seek_timeout_flag && !rstopt_reg, protected_write_error && !rstopt_reg,
        volchg_reg && !rstopt_reg, drive_type_flag, head_select,
        drive_ready, drive_seeking);
    end
    if (hdr_we && !header_cmd)
      hdr_wptr_next = 2'(hdr_wptr_reg + 2'h1);
    if (mpr_read && view_reg == MPSR_V_HEADER && hdr_rptr_reg != 2'h2 && hdr_rptr_reg < hdr_wptr_reg
      && !header_cmd)
      hdr_rptr_next = 2'(hdr_rptr_reg + 2'h1);
    if (word_done && busy_reg)
    begin
      // 13-bit field covers 1..8192 words; wrapping the field to zero ends it
      wcount_next = wc_inc;
      if (wc_inc == 13'h0000)
      begin
        if (!xfer_cmd)
          busy_next = 1'b0;
        end_next = 1'b1;
      end
    end
  end

  // Header words held as they arrive: cylinder, head, sector in word one,
  // CRC in word three, kept verbatim.
  always_ff @(posedge aclk)
  begin
    if (hdr_we)
      hdr_mem[hdr_wptr_reg] <= hdr_wdata;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      view_reg <= MPSR_V_IDLE;
      status_reg <= MPSR_MPR_RST;
      hdr_wptr_reg <= 2'h0;
      hdr_rptr_reg <= 2'h0;
      wcount_reg <= 13'h0000;
      wc_top_reg <= 3'h0;
      volchg_reg <= 1'b0;
      ready_prev_reg <= 1'b0;
      req_reg <= 1'b0;
      rstopt_reg <= 1'b0;
      end_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else
    begin
      view_reg <= view_next;
      status_reg <= status_next;
      hdr_wptr_reg <= hdr_wptr_next;
      hdr_rptr_reg <= hdr_rptr_next;
      wcount_reg <= wcount_next;
      wc_top_reg <= wc_top_next;
      volchg_reg <= volchg_next;
      ready_prev_reg <= ready_prev_next;
      req_reg <= req_next;
      rstopt_reg <= rstopt_next;
      end_reg <= end_next;
      busy_reg <= busy_next;
    end
  end

endmodule

// ### design/mpsr_pkg.sv
/*
  Package for the multipurpose status/count register block: AXI4-Lite register
  offsets, status field positions, reset values and command codes.
  Assumes a 32-bit AXI4-Lite bus with each register on one aligned word.
*/
// Overview of operation
// - Completed status request loads drive status word
// - Bit 13 shows write protection
// - Bit 12 flags seek fault or off line
// - Bit 10 flags write on protected drive
// - Bit 09 sets on ready, cleared by reset-option
// - Bit 07 reports emulated drive type
// - Bit 06 reports currently selected head
// - Bits 05 and 03 set when not ready
// - Bit 04 set when drive ready
// - Bits 02..00 encode drive state
// - Header read presents three words in sequence
// - Word one: cylinder, head, sector fields
// - Word two reads all zeros
// - Word three holds header CRC
// - Cylinder address spans octal 000 to 777
// - Counter increments once per data word
// - Transfer ends when counter overflows to zero
// - Counts from one up to 5120 words; the 13-bit field here takes counts up to 8192
// - Count field is bits 12..0, LSB bit 0
// - Reset option clears error bits before status
package mpsr_pkg;

  // Byte offsets on the AXI4-Lite bus
  localparam logic [7:0] MPSR_OFF_MPR = 8'h00;
  localparam logic [7:0] MPSR_OFF_CMD = 8'h04;
  localparam logic [7:0] MPSR_OFF_STAT = 8'h08;

  // Status word field positions
  localparam int MPSR_ST_WPROT = 13;
  localparam int MPSR_ST_SEEKTO = 12;
  localparam int MPSR_ST_PWERR = 10;
  localparam int MPSR_ST_VOLCHG = 9;
  localparam int MPSR_ST_DTYPE = 7;
  localparam int MPSR_ST_HEAD = 6;
  localparam int MPSR_ST_COVER = 5;
  localparam int MPSR_ST_HEADSOUT = 4;
  localparam int MPSR_ST_BRUSH = 3;

  // Drive state codes, bits 02..00
  localparam logic [2:0] MPSR_STATE_LOAD = 3'h0;
  localparam logic [2:0] MPSR_STATE_SEEK = 3'h4;
  localparam logic [2:0] MPSR_STATE_LOCK = 3'h5;

  // Command register fields
  localparam int MPSR_CMD_RST_BIT = 3;
  localparam logic [1:0] MPSR_CMD_STATUS = 2'h1;
  localparam logic [1:0] MPSR_CMD_HEADER = 2'h2;
  localparam logic [1:0] MPSR_CMD_XFER = 2'h3;

  // Word count field
  localparam int MPSR_WC_W = 13;
  localparam logic [2:0] MPSR_WC_TOP = 3'h7;
  localparam logic [12:0] MPSR_WC_MAX = 13'h1400;
  localparam logic [15:0] MPSR_MPR_RST = 16'h0000;

  typedef enum logic [3:0] {
    MPSR_V_IDLE = 4'h1,
    MPSR_V_STATUS = 4'h2,
    MPSR_V_HEADER = 4'h4,
    MPSR_V_XFER = 4'h8
  } mpsr_view_e;

endpackage

// ### bench/mpsr_top_monitor.sv
/*
  Checker for mpsr_top: bus handshakes, status request and word counter end.
  Assumes it is bound to mpsr_top and sees only that module's ports.
*/
`timescale 1ns/1ps
module mpsr_top_monitor
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic status_done,
  input wire logic status_request,
  input wire logic word_done,
  input wire logic xfer_end
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_req_hold; status_request && !status_done |=> status_request; endproperty
  a_req_hold: assert property (p_req_hold) else $error("status request dropped early");
  property p_req_drop; status_request && status_done |=> !status_request; endproperty
  a_req_drop: assert property (p_req_drop) else $error("status request stuck");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && !s_axi_awready; endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response not held");
  property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_done: assert property (p_b_done) else $error("write response repeated");
  property p_r_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_resp: assert property (p_r_resp) else $error("read answer late");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_end_pulse; xfer_end |=> !xfer_end; endproperty
  a_end_pulse: assert property (p_end_pulse) else $error("transfer end longer than one cycle");
  property p_end_cause; xfer_end |-> $past(word_done) || $past(word_done, 2); endproperty
  a_end_cause: assert property (p_end_cause) else $error("transfer end without a word");
  c_status: cover property (status_request && status_done);
  c_end: cover property (xfer_end);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind mpsr_top mpsr_top_monitor u_mpsr_top_monitor (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .status_done, .status_request,
  .word_done, .xfer_end);

// ### bench/mpsr_drive_model.sv
/*
  Behavioural disk drive: answers status requests and returns header words.
  Assumes the bench sets the status levels itself and pulses hdr_go once.
*/
`timescale 1ns/1ps
module mpsr_drive_model
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic status_request,
  input wire logic hdr_go,
  input wire logic slow,
  input wire logic [15:0] hdr_first,
  input wire logic [15:0] hdr_crc,
  output logic status_done,
  output logic header_valid,
  output logic [15:0] header_word
);
  int cnt;
  // A slow drive takes twenty-one cycles, so the request must stand meanwhile
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt <= 0;
      status_done <= 1'b0;
    end
    else if (status_request && !status_done && cnt == (slow ? 20 : 1))
    begin
      cnt <= 0;
      status_done <= 1'b1;
    end
    else
    begin
      status_done <= 1'b0;
      if (status_request && !status_done)
        cnt <= cnt + 1;
    end
  end
  initial
  begin
    header_valid = 1'b0;
    header_word = 16'h0000;
    forever
    begin
      @(posedge aclk);
      if (hdr_go)
        for (int i = 0; i < 3; i++)
        begin
          repeat (slow ? 3 : 1) @(posedge aclk);
          header_valid <= 1'b1;
          header_word <= (i == 0) ? hdr_first : (i == 1) ? 16'h0000 : hdr_crc;
          @(posedge aclk);
          header_valid <= 1'b0;
          // Released bus shows the inverse so a stale word cannot pass
          header_word <= ~header_word;
        end
    end
  end
endmodule

// ### bench/mpsr_top_tb.sv
/*
  Self-checking bench for mpsr_top: status view, header view, word counter.
  Assumes the drive model answers status requests and header reads.
*/
`timescale 1ns/1ps
module mpsr_top_tb;
  import mpsr_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, status_done, header_valid, status_request, reset_opt, xfer_end;
  logic [3:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp;
  logic wp = 0, sto = 0, pwe = 0, dt = 0, hs = 0, rdy = 0, sk = 0, word_done = 0, hdr_go = 0, slow = 0;
  logic [15:0] header_word;
  int err_count = 0, checks_done = 0, end_cnt = 0;
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) if (xfer_end === 1'b1) end_cnt++;
  mpsr_top u_mpsr_top (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .status_done, .write_protected_flag(wp), .seek_timeout_flag(sto),
    .protected_write_error(pwe), .drive_type_flag(dt), .head_select(hs), .drive_ready(rdy), .drive_seeking(sk),
    .header_valid, .header_word, .word_done, .status_request, .status_reset_opt(reset_opt), .xfer_end);
  mpsr_drive_model u_mpsr_drive_model (.aclk, .aresetn, .status_request, .hdr_go, .slow,
    .hdr_first(16'hffdf), .hdr_crc(16'h5a3c), .status_done, .header_valid, .header_word);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (awvalid && awready) begin aw_ok = 1; awvalid <= 0; end
      if (wvalid && wready) begin w_ok = 1; wvalid <= 0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 0;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    chk("rdata", e, rdata);
  endtask
  task automatic late_rd(input logic [31:0] e);
    araddr <= 4'h0;
    arvalid <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    repeat (3) @(posedge aclk);
    rready <= 1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 0;
    chk("late rdata", e, rdata);
  endtask
  task automatic do_status(input logic [6:0] cfg, input logic rst, input logic [15:0] e);
    {wp, sto, pwe, dt, hs, rdy, sk} <= cfg;
    axi_wr(4'h4, {28'h0, rst, 1'b0, MPSR_CMD_STATUS}, 2'h0);
    chk("reset option", {31'h0, rst}, {31'h0, reset_opt});
    while (status_request !== 1'b0) @(posedge aclk);
    repeat (2) @(posedge aclk);
    axi_rd(4'h0, {16'h0, e}, 2'h0);
  endtask
  task automatic do_header();
    axi_wr(4'h4, {30'h0, MPSR_CMD_HEADER}, 2'h0);
    hdr_go <= 1;
    @(posedge aclk);
    hdr_go <= 0;
    repeat (16) @(posedge aclk);
    axi_rd(4'h0, 32'h0000ffdf, 2'h0);
    axi_rd(4'h0, 32'h00000000, 2'h0);
    axi_rd(4'h0, 32'h00005a3c, 2'h0);
  endtask
  task automatic do_xfer(input logic [15:0] cnt_word, input int words);
    end_cnt = 0;
    axi_wr(4'h0, {16'h0, cnt_word}, 2'h0);
    axi_rd(4'h0, {16'h0, cnt_word}, 2'h0);
    axi_wr(4'h4, {30'h0, MPSR_CMD_XFER}, 2'h0);
    for (int i = 0; i < words - 1; i++)
    begin
      word_done <= 1; @(posedge aclk);
      word_done <= 0; @(posedge aclk);
    end
    repeat (3) @(posedge aclk);
    axi_rd(4'h0, 32'h0000ffff, 2'h0);
    chk("early end", 0, end_cnt);
    word_done <= 1; @(posedge aclk);
    word_done <= 0; repeat (4) @(posedge aclk);
    chk("end pulses", 1, end_cnt);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge aclk);
    err_count++;
    complete_run();
  end
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    axi_rd(4'h0, 32'h0, 2'h0);
    axi_rd(4'hc, 32'h0, 2'h2);
    axi_rd(4'h4, 32'h0, 2'h2);
    axi_wr(4'h8, 32'hf, 2'h2);
    do_status(7'b0000000, 0, 16'h0028);
    late_rd(32'h00000028);
    slow <= 1;
    do_status(7'b1111110, 0, 16'h36d5);
    axi_rd(4'h8, 32'h1, 2'h0);
    do_status(7'b1111110, 1, 16'h20d5);
    axi_rd(4'h8, 32'h0, 2'h0);
    slow <= 0;
    do_status(7'b0000011, 0, 16'h0014);
    do_header();
    slow <= 1;
    do_header();
    do_xfer(16'hffff, 1);
    do_xfer(16'hec00, 5120);
    complete_run();
  end
endmodule
